/* pkg/prp_defs.svh */
`ifndef PRP_DEFS_SVH
`define PRP_DEFS_SVH
// Word address, data and bit-select widths of the memory.
`define PRP_AW 9
`define PRP_DW 8
`define PRP_BW 3
// Width of the sequence counter and of the checker age counters.
`define PRP_CW 17
`define PRP_AGE_MAX 17'h1FFFF
`define PRP_AGE_ONE 17'h00001
// Clock period in ns.
`define PRP_CLK_NS 100
// Least gap around supply and select edges, and its longest value, in ns.
`define PRP_T_GAP_NS 10000
`define PRP_T_GAPMAX_NS 1000000
// Select pulse while the supply is raised, in ns.
`define PRP_T_CS_NS 1000000
// Allowed length of the raised-supply pulse, in ns.
`define PRP_T_PMIN_NS 900000
`define PRP_T_PMAX_NS 10000000
// Largest duty cycle of the raised supply, in percent.
`define PRP_DUTY_PCT 35
`define PRP_FULL_PCT 100
// Cycles from select low to sampling the data pins.
`define PRP_SETTLE_CYC 2
// Level of the select pins while outputs are off.
`define PRP_CS_OFF 1'b1
`endif

/* pkg/prp_pkg.sv */
`include "prp_defs.svh"
`default_nettype none
package prp_pkg;
  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    st_idle, st_sense, st_arm, st_rise, st_pulse,
    st_hold, st_settle, st_verify, st_cool
  } prp_state_t;

  // One request: read a word, or bring one bit to a value.
  typedef struct packed {
    logic                prog;
    logic [`PRP_AW-1:0]  addr;
    logic [`PRP_BW-1:0]  bit_idx;
    logic                value;
  } prp_cmd_t;

  // Answer to the user side.
  typedef struct packed {
    logic                busy;
    logic                done;
    logic                skip;
    logic                fail;
    logic [`PRP_DW-1:0]  rdata;
  } prp_status_t;

  // Whole state of the programmer.
  typedef struct packed {
    prp_state_t          st;
    logic [`PRP_CW-1:0]  cnt;
    prp_cmd_t            cmd;
    logic                cs_b;
    logic                vpp;
    logic [`PRP_DW-1:0]  sel;
    prp_status_t         stat;
  } prp_regs_t;
endpackage : prp_pkg
`default_nettype wire

/* src/prp_programmer.sv */
`include "prp_defs.svh"
`default_nettype none
// Behaviour
// (R1) Device enables outputs when all selects active.
// (R2) Any inactive select turns all outputs off.
// (R3) Blank bits read one level; programming inverts.
// (R4) Programmed bit never returns to blank.
// (R5) Blank bits stay programmable in later sessions.
// (R6) Reading never alters stored bits.
// (R7) One bit per pulse, word held stable.
// (R8) Read bit first; skip if already correct.
// (R9) Select inactive before raising the supply.
// (R10) Select low 10 us to 1 ms after rise.
// (R11) Hold select low 1 ms, then raise.
// (R12) Lower supply 10 us to 1 ms later.
// (R13) Verify read only 10 us after supply drop.
// (R14) Repeat per bit, duty cycle at most 35%.
// (R15) Raised-supply pulse lasts 0.9 to 10 ms.
// (R16) Single programming attempt per bit, no retry.
// (R17) Open-collector outputs only pull low.
// (R18) Address selects word; read path is combinational.
module prp_programmer #(
  parameter int CS_CYC   = `PRP_T_CS_NS / `PRP_CLK_NS,
  parameter int COOL_CYC =
    (((2 * ((`PRP_T_GAP_NS + `PRP_CLK_NS - 1) / `PRP_CLK_NS)) + CS_CYC)
     * (`PRP_FULL_PCT - `PRP_DUTY_PCT) + `PRP_DUTY_PCT - 1)
    / `PRP_DUTY_PCT
) (
  input  wire logic               core_clk_in,    // 10 MHz clock.
  input  wire logic               rst_b_in,       // Sync reset, low.
  input  wire logic               ce_in,          // Clock enable.
  input  wire logic               cmd_valid_in,   // Request strobe.
  input  wire prp_pkg::prp_cmd_t  cmd_in,         // Request fields.
  input  wire logic               blank_high_in,  // Blank bits read 1.
  input  wire logic [`PRP_DW-1:0] prom_data_in,   // Memory data pins.
  output var  prp_pkg::prp_status_t status_out,   // Answer to user.
  output logic [`PRP_AW-1:0]      prom_addr_out,  // Memory address.
  output logic                    prom_cs_b_out,  // Select, low active.
  output logic                    prog_supply_hi_out, // Raise supply.
  output logic [`PRP_DW-1:0]      target_output_program_level_out // Pin.
);
  // ---------------------------------------------------------------------
  // Derived cycle counts
  // ---------------------------------------------------------------------
  // Least times round up, longest times round down.
  localparam int GAP_CYC =
    (`PRP_T_GAP_NS + `PRP_CLK_NS - 1) / `PRP_CLK_NS;
  localparam int GAPMAX_CYC = `PRP_T_GAPMAX_NS / `PRP_CLK_NS;
  localparam int PMIN_CYC =
    (`PRP_T_PMIN_NS + `PRP_CLK_NS - 1) / `PRP_CLK_NS;
  localparam int PMAX_CYC = `PRP_T_PMAX_NS / `PRP_CLK_NS;
  // Select pulse that the fuse needs, whatever CS_CYC is set to.
  localparam int CS_RULE_CYC = `PRP_T_CS_NS / `PRP_CLK_NS;
  localparam logic [`PRP_CW-1:0] GAP_LD  = `PRP_CW'(GAP_CYC - 1);
  localparam logic [`PRP_CW-1:0] CS_LD   = `PRP_CW'(CS_CYC - 1);
  localparam logic [`PRP_CW-1:0] COOL_LD = `PRP_CW'(COOL_CYC - 1);
  localparam logic [`PRP_CW-1:0] SET_LD  = `PRP_CW'(`PRP_SETTLE_CYC - 1);
  localparam logic [`PRP_CW-1:0] CNT_ZERO = '0;
  localparam logic [`PRP_DW-1:0] SEL_ONE = `PRP_DW'(1);

  prp_pkg::prp_regs_t r;
  prp_pkg::prp_regs_t n;
  logic               bit_now;
  logic               cnt_end;

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  // The bit under test is taken straight from the data pins; the
  // memory read path has no latch, so the value is valid after settle.
  assign bit_now = prom_data_in[r.cmd.bit_idx];
  assign cnt_end = (r.cnt == CNT_ZERO);

  // Sequencer: sense, then raised-supply pulse, then verify and rest.
  always_comb begin
    n = r;
    n.stat.done = 1'b0;
    if (!cnt_end) begin
      n.cnt = r.cnt - `PRP_CW'(1);
    end
    case (r.st)
      prp_pkg::st_idle: begin
        if (cmd_valid_in) begin
          n.cmd       = cmd_in;
          n.stat.busy = 1'b1;
          n.stat.skip = 1'b0;
          n.stat.fail = 1'b0;
          // (R18) address then read
          n.cs_b      = ~`PRP_CS_OFF;
          n.cnt       = SET_LD;
          n.st        = prp_pkg::st_sense;
        end
      end
      prp_pkg::st_sense: begin
        if (cnt_end) begin
          n.stat.rdata = prom_data_in;
          n.cs_b       = `PRP_CS_OFF;
          if (!r.cmd.prog) begin
            n.stat.done = 1'b1;
            n.stat.busy = 1'b0;
            n.st        = prp_pkg::st_idle;
          // (R8) skip correct bit
          end else if (bit_now == r.cmd.value) begin
            n.stat.skip = 1'b1;
            n.stat.done = 1'b1;
            n.stat.busy = 1'b0;
            n.st        = prp_pkg::st_idle;
          // (R4) cannot return blank
          end else if (bit_now != blank_high_in) begin
            n.stat.fail = 1'b1;
            n.stat.done = 1'b1;
            n.stat.busy = 1'b0;
            n.st        = prp_pkg::st_idle;
          end else begin
            // (R5) blank bit programmable
            // (R7) single target output
            n.sel = SEL_ONE << r.cmd.bit_idx;
            n.cnt = GAP_LD;
            n.st  = prp_pkg::st_arm;
          end
        end
      end
      prp_pkg::st_arm: begin
        // (R9) outputs off first
        if (cnt_end) begin
          n.vpp = 1'b1;
          n.cnt = GAP_LD;
          n.st  = prp_pkg::st_rise;
        end
      end
      prp_pkg::st_rise: begin
        // (R10) select after rise
        if (cnt_end) begin
          n.cs_b = ~`PRP_CS_OFF;
          n.cnt  = CS_LD;
          n.st   = prp_pkg::st_pulse;
        end
      end
      prp_pkg::st_pulse: begin
        // (R11) end select pulse
        if (cnt_end) begin
          n.cs_b = `PRP_CS_OFF;
          n.cnt  = GAP_LD;
          n.st   = prp_pkg::st_hold;
        end
      end
      prp_pkg::st_hold: begin
        // (R12) lower the supply
        // (R15) pulse length bounded
        if (cnt_end) begin
          n.vpp = 1'b0;
          n.sel = '0;
          n.cnt = GAP_LD;
          n.st  = prp_pkg::st_settle;
        end
      end
      prp_pkg::st_settle: begin
        // (R13) wait before verify
        if (cnt_end) begin
          n.cs_b = ~`PRP_CS_OFF;
          n.cnt  = SET_LD;
          n.st   = prp_pkg::st_verify;
        end
      end
      prp_pkg::st_verify: begin
        if (cnt_end) begin
          n.stat.rdata = prom_data_in;
          // (R16) report, never retry
          n.stat.fail  = (bit_now != r.cmd.value);
          n.cs_b       = `PRP_CS_OFF;
          n.cnt        = COOL_LD;
          n.st         = prp_pkg::st_cool;
        end
      end
      prp_pkg::st_cool: begin
        // (R14) keep duty cycle
        if (cnt_end) begin
          n.stat.done = 1'b1;
          n.stat.busy = 1'b0;
          n.st        = prp_pkg::st_idle;
        end
      end
      default: begin
        n.st = prp_pkg::st_idle;
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  // Reset leaves the select off so the memory never drives during reset.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      r      <= '0;
      r.cs_b <= `PRP_CS_OFF;
      r.st   <= prp_pkg::st_idle;
    end else if (ce_in) begin
      r <= n;
    end
  end

  // Every output is a field of the state register.
  assign status_out                      = r.stat;
  assign prom_addr_out                   = r.cmd.addr;
  assign prom_cs_b_out                   = r.cs_b;
  assign prog_supply_hi_out              = r.vpp;
  assign target_output_program_level_out = r.sel;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  // Age counters: cycles the supply and select pins have held their present level,
  // saturating so that a long idle stretch always satisfies the least-gap checks.
  logic [`PRP_CW-1:0] vpp_age_r;
  logic [`PRP_CW-1:0] cs_age_r;
  // Length of the last raised-supply pulse, kept for the duty check.
  logic [`PRP_CW-1:0] on_len_r;

  function automatic logic [`PRP_CW-1:0] prp_inc(
    input logic [`PRP_CW-1:0] a
  );
    prp_inc = (a == `PRP_AGE_MAX) ? a : a + `PRP_AGE_ONE;
  endfunction : prp_inc

  // Helper counters follow the same enable as the state.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      vpp_age_r <= `PRP_AGE_MAX;
      cs_age_r  <= `PRP_AGE_MAX;
      on_len_r  <= '0;
    end else if (ce_in) begin
      vpp_age_r <= (n.vpp != r.vpp) ? `PRP_AGE_ONE : prp_inc(vpp_age_r);
      cs_age_r  <= (n.cs_b != r.cs_b) ? `PRP_AGE_ONE : prp_inc(cs_age_r);
      on_len_r  <= (r.vpp && !n.vpp) ? vpp_age_r : on_len_r;
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_rise;
    $rose(r.vpp);
  endsequence
  sequence s_drop;
    $fell(r.vpp);
  endsequence

  property p_off_first;
    s_rise |-> r.cs_b && $past(r.cs_b);
  endproperty
  a_off_first: assert property (p_off_first) // R9
    else $error("Supply raised while select active.");

  property p_sel_delay;
    $fell(r.cs_b) && r.vpp |->
      $past(vpp_age_r) >= GAP_CYC && $past(vpp_age_r) <= GAPMAX_CYC;
  endproperty
  a_sel_delay: assert property (p_sel_delay) // R10
    else $error("Select fell outside window after supply rise.");

  property p_sel_len;
    $rose(r.cs_b) && r.vpp |-> $past(cs_age_r) == CS_RULE_CYC;
  endproperty
  a_sel_len: assert property (p_sel_len) // R11
    else $error("Select pulse length wrong.");

  property p_drop_delay;
    s_drop |-> r.cs_b &&
      $past(cs_age_r) >= GAP_CYC && $past(cs_age_r) <= GAPMAX_CYC;
  endproperty
  a_drop_delay: assert property (p_drop_delay) // R12
    else $error("Supply dropped outside window after select rise.");

  property p_verify_wait;
    $fell(r.cs_b) && !r.vpp |-> $past(vpp_age_r) >= GAP_CYC;
  endproperty
  a_verify_wait: assert property (p_verify_wait) // R13
    else $error("Select low too soon after supply drop.");

  // Off time against the last on time, so a short cool-down is caught
  // whatever COOL_CYC holds.
  property p_duty;
    s_rise |-> int'($past(vpp_age_r)) * `PRP_DUTY_PCT >=
      int'(on_len_r) * (`PRP_FULL_PCT - `PRP_DUTY_PCT);
  endproperty
  a_duty: assert property (p_duty) // R14
    else $error("Supply off time too short for duty cycle.");

  property p_pulse_len;
    s_drop |->
      $past(vpp_age_r) >= PMIN_CYC && $past(vpp_age_r) <= PMAX_CYC;
  endproperty
  a_pulse_len: assert property (p_pulse_len) // R15
    else $error("Programming pulse length out of range.");

  property p_one_bit;
    r.vpp |-> $onehot(r.sel) && r.sel[r.cmd.bit_idx];
  endproperty
  a_one_bit: assert property (p_one_bit) // R7
    else $error("Target output not a single selected bit.");

  property p_skip;
    ce_in && r.st == prp_pkg::st_sense && cnt_end && r.cmd.prog &&
      bit_now == r.cmd.value |=>
      r.stat.done && r.stat.skip && !r.vpp ##1 !r.vpp;
  endproperty
  a_skip: assert property (p_skip) // R8
    else $error("Correct bit was not skipped.");

  property p_no_unblank;
    ce_in && r.st == prp_pkg::st_sense && cnt_end && r.cmd.prog &&
      bit_now != r.cmd.value && bit_now != blank_high_in |=>
      r.stat.fail && r.stat.done && !r.vpp;
  endproperty
  a_no_unblank: assert property (p_no_unblank) // R4
    else $error("Attempt to return a bit to blank.");

  property p_no_retry;
    r.stat.fail && r.stat.busy |-> !r.vpp && r.cs_b;
  endproperty
  a_no_retry: assert property (p_no_retry) // R16
    else $error("Pulse repeated after failed verify.");
endmodule : prp_programmer
`default_nettype wire

/* testbench/prp_prom_model.sv */
`include "prp_defs.svh"
`default_nettype none
// ---------------------------------------------------------------------
// Fuse memory seen from its pins
// ---------------------------------------------------------------------
module prp_prom_model (
  input  wire logic               supply_hi_in, // Raised supply.
  input  wire logic               cs_b_in,      // Select, low active.
  input  wire logic [`PRP_AW-1:0] addr_in,      // Word address.
  input  wire logic [`PRP_DW-1:0] target_in,    // One-hot program pin.
  input  wire logic               blank_hi_in,  // Blank bits read 1.
  input  wire logic               stuck_in,     // Fuse will not open.
  output var  logic [`PRP_DW-1:0] data_out,     // Data pins.
  output var  int                 viol_out,     // Sequence faults seen.
  output var  int                 pulse_out     // Select pulses at raise.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [`PRP_DW-1:0] blown [2**`PRP_AW];
  logic [`PRP_DW-1:0] word;
  logic [`PRP_DW-1:0] last;
  realtime            t_rise;
  realtime            t_csh;
  realtime            t_fall;

  // All fuses intact; a far past fall keeps the first read legal.
  initial begin
    foreach (blown[i]) blown[i] = 8'h00;
    viol_out = 0;
    pulse_out = 0;
    last = 8'h00;
    t_fall = -1.0e9;
  end

  always_comb word = blown[addr_in] ^ {`PRP_DW{blank_hi_in}};

  // outputs off unless selected.
  // Released pins show the inverse of the last word, so a stale sample
  // cannot pass by luck.
  always_comb data_out = cs_b_in ? ~last : word;

  // one fuse per pulse, fuses only open.
  always @(posedge cs_b_in) begin
    last = word;
    if (supply_hi_in === 1'b1) begin
      pulse_out++;
      t_csh = $realtime;
      if ($countones(target_in) != 1) viol_out++;
      else if (stuck_in !== 1'b1) blown[addr_in] = blown[addr_in] | target_in;
    end
  end

  always @(posedge supply_hi_in) begin
    t_rise = $realtime;
    if (cs_b_in !== `PRP_CS_OFF) viol_out++;
  end

  // select window after raise, least gap only after drop.
  always @(negedge cs_b_in) begin
    if (supply_hi_in === 1'b1) begin
      if ($realtime - t_rise < `PRP_T_GAP_NS ||
          $realtime - t_rise > `PRP_T_GAPMAX_NS) viol_out++;
    end else if ($realtime - t_fall < `PRP_T_GAP_NS) viol_out++;
  end

  // drop window; the fall out of reset is not a pulse.
  always @(negedge supply_hi_in) begin
    if (pulse_out > 0) begin
      t_fall = $realtime;
      if (t_fall - t_csh < `PRP_T_GAP_NS ||
          t_fall - t_csh > `PRP_T_GAPMAX_NS) viol_out++;
    end
  end

  always @(addr_in) begin
    if (supply_hi_in === 1'b1) viol_out++;
  end
endmodule : prp_prom_model
`default_nettype wire

/* testbench/tb_prp_programmer.sv */
`include "prp_defs.svh"
`default_nettype none
module tb_prp_programmer;
  timeunit 1ns;
  timeprecision 1ns;
  // Select pulse and cool-down at their legal lengths; one programming
  // request takes about 29,000 cycles, so the run has room for three.
  localparam int GAP = `PRP_T_GAP_NS / `PRP_CLK_NS;
  localparam int CS_SIM = `PRP_T_CS_NS / `PRP_CLK_NS;
  localparam int COOL_SIM =
    ((2 * GAP + CS_SIM) * (`PRP_FULL_PCT - `PRP_DUTY_PCT)
     + `PRP_DUTY_PCT - 1) / `PRP_DUTY_PCT;
  localparam int PROG_N = 2 * `PRP_SETTLE_CYC + 4 * GAP + CS_SIM + COOL_SIM;
  localparam int LIMIT = 95000;
  logic                 core_clk_in;
  logic                 rst_b_in;
  logic                 ce_in;
  logic                 cmd_valid_in;
  prp_pkg::prp_cmd_t    cmd_in;
  logic                 blank_hi;
  logic                 stuck;
  logic [`PRP_DW-1:0]   data;
  prp_pkg::prp_status_t status;
  logic [`PRP_AW-1:0]   addr;
  logic                 cs_b;
  logic                 supply;
  logic [`PRP_DW-1:0]   target;
  int                   viol;
  int                   pulses;
  logic                 busy_seen;
  int                   fail_count = 0;
  int                   check_count = 0;
  int                   cyc = 0;

  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end

  prp_programmer #(.CS_CYC(CS_SIM), .COOL_CYC(COOL_SIM)) i_prp_programmer (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .blank_high_in(blank_hi),
    .prom_data_in(data), .status_out(status), .prom_addr_out(addr),
    .prom_cs_b_out(cs_b), .prog_supply_hi_out(supply),
    .target_output_program_level_out(target));

  prp_prom_model i_prp_prom_model (
    .supply_hi_in(supply), .cs_b_in(cs_b), .addr_in(addr),
    .target_in(target), .blank_hi_in(blank_hi), .stuck_in(stuck),
    .data_out(data), .viol_out(viol), .pulse_out(pulses));

  task check(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %0h seen %0h", name, e, g);
    end
  endtask : check

  task summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // A hang counts as a mismatch and still reaches the report.
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == LIMIT) begin
      fail_count++;
      summarize();
    end
  end

  // One request; n counts edges from take to done, ce low for k edges.
  task automatic run(input logic p, input logic [8:0] a, input logic [2:0] b,
                     input logic v, input int k, output int n);
    @(posedge core_clk_in);
    cmd_valid_in <= 1'b1;
    cmd_in <= '{prog: p, addr: a, bit_idx: b, value: v};
    @(posedge core_clk_in);
    cmd_valid_in <= 1'b0;
    n = 0;
    // Outputs are read at the falling edge, where they have settled.
    @(negedge core_clk_in);
    busy_seen = status.busy;
    while (n < 2 * PROG_N && status.done !== 1'b1) begin
      @(posedge core_clk_in);
      n++;
      if (k > 0 && n == 1) ce_in <= 1'b0;
      if (k > 0 && n == 1 + k) ce_in <= 1'b1;
      @(negedge core_clk_in);
    end
  endtask : run

  task automatic t_read;
    int n;
    run(1'b0, 9'h005, 3'h0, 1'b0, 0, n);
    check("read_cycles", `PRP_SETTLE_CYC, n);
    check("read_blank", 8'h00, status.rdata);
    check("read_addr", 9'h005, addr);
    check("read_cs_off", 1'b1, cs_b);
    check("read_busy", 1'b1, busy_seen);
    check("read_idle", 1'b0, status.busy);
    run(1'b0, 9'h005, 3'h0, 1'b0, 4, n);
    check("ce_stretch", `PRP_SETTLE_CYC + 4, n);
    $display("test read done");
  endtask : t_read

  task automatic t_prog;
    int n;
    int p0;
    p0 = pulses;
    run(1'b1, 9'h005, 3'h3, 1'b1, 0, n);
    check("prog_cycles", PROG_N, n);
    check("prog_fail", 1'b0, status.fail);
    check("prog_pulses", p0 + 1, pulses);
    check("prog_target", 8'h00, target);
    check("prog_supply", 1'b0, supply);
    run(1'b0, 9'h005, 3'h0, 1'b0, 0, n);
    check("prog_read", 8'h08, status.rdata);
    run(1'b1, 9'h005, 3'h3, 1'b1, 0, n);
    check("skip_flag", 1'b1, status.skip);
    check("skip_cycles", `PRP_SETTLE_CYC, n);
    run(1'b1, 9'h005, 3'h3, 1'b0, 0, n);
    check("undo_fail", 1'b1, status.fail);
    check("no_pulse", p0 + 1, pulses);
    $display("test program done");
  endtask : t_prog

  task automatic t_stuck;
    int n;
    int p0;
    p0 = pulses;
    stuck <= 1'b1;
    run(1'b1, 9'h006, 3'h0, 1'b1, 0, n);
    stuck <= 1'b0;
    check("stuck_fail", 1'b1, status.fail);
    check("one_try", p0 + 1, pulses);
    run(1'b0, 9'h006, 3'h0, 1'b0, 0, n);
    check("stuck_read", 8'h00, status.rdata);
    $display("test stuck done");
  endtask : t_stuck

  task automatic t_inv;
    int n;
    blank_hi <= 1'b1;
    run(1'b0, 9'h007, 3'h0, 1'b0, 0, n);
    check("inv_blank", 8'hFF, status.rdata);
    // A further bit on the partly programmed word of the earlier test.
    run(1'b1, 9'h005, 3'h7, 1'b0, 0, n);
    check("inv_fail", 1'b0, status.fail);
    run(1'b0, 9'h005, 3'h0, 1'b0, 0, n);
    check("inv_read", 8'h77, status.rdata);
    blank_hi <= 1'b0;
    run(1'b0, 9'h005, 3'h0, 1'b0, 0, n);
    check("later_bit", 8'h88, status.rdata);
    check("seq_faults", 0, viol);
    $display("test inverted done");
  endtask : t_inv

  initial begin
    rst_b_in = 1'b0;
    ce_in = 1'b1;
    cmd_valid_in = 1'b0;
    cmd_in = '0;
    blank_hi = 1'b0;
    stuck = 1'b0;
    repeat (5) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    t_read();
    t_prog();
    t_stuck();
    t_inv();
    summarize();
  end
endmodule : tb_prp_programmer
`default_nettype wire
